// ---- pkg/pdc_pkg.sv ----
/*
 * constants, register map and carrier types of the page interleave
 * dram controller; assumes a 20 MHz core clock and an apb register bus
 */
package pdc_pkg;

	// ------------------------------------------------------------------
	// clock
	// ------------------------------------------------------------------
	localparam int unsigned CLK_NS = 50;

	// ------------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0]  IDX_MEMCFG  = 8'h08;
	localparam logic [7:0]  IDX_TIMING  = 8'h13;
	localparam logic [7:0]  IDX_STATUS  = 8'h14;
	localparam logic [7:0]  IDX_BANKCFG = 8'h15;
	localparam logic [11:0] ADR_MEMCFG  = {2'h0, IDX_MEMCFG, 2'h0};
	localparam logic [11:0] ADR_TIMING  = {2'h0, IDX_TIMING, 2'h0};
	localparam logic [11:0] ADR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] ADR_BANKCFG = {2'h0, IDX_BANKCFG, 2'h0};

	// ------------------------------------------------------------------
	// fields, masks and reset values
	// ------------------------------------------------------------------
	localparam int unsigned MEMCFG_ILV_BIT  = 0;
	localparam int unsigned TIM_LONG_BIT    = 7;
	localparam int unsigned TIM_WAIT_BIT    = 6;
	localparam int unsigned BANK_FOUR_BIT   = 0;
	localparam int unsigned BANK_P0_1M_BIT  = 1;
	localparam int unsigned BANK_P1_1M_BIT  = 2;
	localparam int unsigned STAT_BUSY_BIT   = 0;
	localparam int unsigned STAT_REF_BIT    = 1;
	localparam int unsigned STAT_RAS_LSB    = 4;
	localparam logic [7:0]  MEMCFG_MASK     = 8'h01;
	localparam logic [7:0]  TIMING_MASK     = 8'hC0;
	localparam logic [7:0]  BANKCFG_MASK    = 8'h07;
	localparam logic [7:0]  MEMCFG_RST      = 8'h00;
	localparam logic [7:0]  TIMING_RST      = 8'h40;
	localparam logic [7:0]  BANKCFG_RST     = 8'h00;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned OSC_TICK_NS   = 840;
	localparam int unsigned RAS_SHORT_NS  = 10_000;
	localparam int unsigned RAS_LONG_NS   = 30_000;
	localparam logic [5:0]  RAS_SHORT_TCK = 6'(RAS_SHORT_NS / OSC_TICK_NS);
	localparam logic [5:0]  RAS_LONG_TCK  = 6'(RAS_LONG_NS / OSC_TICK_NS);
	localparam int unsigned PRECH_NS      = 100;
	localparam int unsigned REF_HOLD_NS   = 100;
	localparam logic [2:0]  PRECH_CYC     =
		3'((PRECH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0]  REF_HOLD_CYC  =
		3'((REF_HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0]  REF_STEPS     = 3'h4;
	localparam logic [2:0]  CAS_BASE_CYC  = 3'h1;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_PRE, ST_ROW, ST_CAS, ST_DONE, ST_DMA_END,
		ST_REF_OFF, ST_REF_ON, ST_REF_HOLD
	} pdc_state_e;

	typedef struct packed {
		logic [3:0] ras_n;
		logic [3:0] cas_n;
		logic       we_n;
		logic [9:0] addr;
	} pdc_dram_s;

	typedef struct packed {
		logic [1:0] bank;
		logic [9:0] row;
		logic [9:0] col;
	} pdc_map_s;

endpackage

// ---- hdl/pdc_ctrl.sv ----
/*
 * page interleave dram controller: arbitration of cpu, dma and refresh,
 * open page tracking per bank, row and column selection, ras timeout.
 * assumes the cpu request is on I_CLK and held until ready; dma, refresh
 * and oscillator inputs are asynchronous and synchronised here.
 */

module pdc_ctrl (
	// clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_ARST_N,
	// apb slave
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [11:0]       I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic [31:0]            O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	// cpu local bus
	input  wire logic              I_CPU_REQ,
	input  wire logic              I_CPU_WRITE,
	input  wire logic [23:2]       I_ADDR,
	input  wire logic [3:0]        I_BYTE_ENABLE_N,
	output logic                   O_CPU_READY,
	// dma, refresh and oscillator pins
	input  wire logic              I_DMA_HOLD_ACK,
	input  wire logic              I_XBUS_MEM_READ_CMD,
	input  wire logic              I_XBUS_MEM_WRITE_CMD,
	input  wire logic              I_REFRESH_REQUEST,
	input  wire logic              I_OSC_DIV_TWELVE_CLOCK,
	// dram array
	output pdc_pkg::pdc_dram_s     O_DRAM
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	pdc_pkg::pdc_state_e state_r;
	pdc_pkg::pdc_state_e state_nxt;
	pdc_pkg::pdc_map_s   map;
	logic [2:0]          cnt_r;
	logic [4:0]          sync1_r;
	logic [4:0]          sync2_r;
	logic [4:0]          sync3_r;
	logic [4:0]          flt_r;
	logic                osc_prev_r;
	logic                osc_tick;
	logic                hold_lvl;
	logic                rd_lvl;
	logic                wr_lvl;
	logic                ref_lvl;
	logic                dma_go;
	logic                hit;
	logic [7:0]          memcfg_r;
	logic [7:0]          timing_r;
	logic [7:0]          bankcfg_r;
	logic [31:0]         prdata_r;
	logic                addr_ok;
	logic [3:0]          ras_on_r;
	logic [3:0]          ras_set;
	logic [9:0]          page_row_r [4];
	logic [1:0]          cur_bank_r;
	logic [9:0]          cur_row_r;
	logic [9:0]          cur_col_r;
	logic                is_dma_r;
	logic                wr_r;
	logic [3:0]          be_r;
	logic [9:0]          ref_row_r;
	logic [3:0]          cas_n_r;
	logic                we_n_r;
	logic [9:0]          addr_r;
	logic [5:0]          tmo_lim;
	wire logic [3:0]     bank_tmo;
	logic                cas_last;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	// a level counts only once the second and third stage agree
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sync1_r    <= 5'h00;
			sync2_r    <= 5'h00;
			sync3_r    <= 5'h00;
			flt_r      <= 5'h00;
			osc_prev_r <= 1'b0;
		end else begin
			sync1_r    <= {I_OSC_DIV_TWELVE_CLOCK, I_REFRESH_REQUEST,
				I_XBUS_MEM_WRITE_CMD, I_XBUS_MEM_READ_CMD,
				I_DMA_HOLD_ACK};
			sync2_r    <= sync1_r;
			sync3_r    <= sync2_r;
			flt_r      <= (~(sync2_r ^ sync3_r) & sync3_r)
				| ((sync2_r ^ sync3_r) & flt_r);
			osc_prev_r <= flt_r[4];
		end
	end

	assign hold_lvl = flt_r[0];
	assign rd_lvl   = flt_r[1];
	assign wr_lvl   = flt_r[2];
	assign ref_lvl  = flt_r[3];
	assign osc_tick = flt_r[4] & ~osc_prev_r;
	assign dma_go   = hold_lvl & (rd_lvl | wr_lvl);

	// ------------------------------------------------------------------
	// apb registers
	// ------------------------------------------------------------------
	assign addr_ok = (I_PADDR == pdc_pkg::ADR_MEMCFG)
		| (I_PADDR == pdc_pkg::ADR_TIMING)
		| (I_PADDR == pdc_pkg::ADR_STATUS)
		| (I_PADDR == pdc_pkg::ADR_BANKCFG);
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
	assign O_PRDATA  = prdata_r;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			memcfg_r  <= pdc_pkg::MEMCFG_RST;
			timing_r  <= pdc_pkg::TIMING_RST;
			bankcfg_r <= pdc_pkg::BANKCFG_RST;
		end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
			if (I_PADDR == pdc_pkg::ADR_MEMCFG)
				memcfg_r <= I_PWDATA[7:0] & pdc_pkg::MEMCFG_MASK;
			if (I_PADDR == pdc_pkg::ADR_TIMING)
				timing_r <= I_PWDATA[7:0] & pdc_pkg::TIMING_MASK;
			if (I_PADDR == pdc_pkg::ADR_BANKCFG)
				bankcfg_r <= I_PWDATA[7:0] & pdc_pkg::BANKCFG_MASK;
		end
	end

	// read data captured in the setup cycle, shown in the access cycle
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			prdata_r <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE) begin
			prdata_r <= 32'h0000_0000;
			case (I_PADDR)
				pdc_pkg::ADR_MEMCFG:  prdata_r[7:0] <= memcfg_r;
				pdc_pkg::ADR_TIMING:  prdata_r[7:0] <= timing_r;
				pdc_pkg::ADR_BANKCFG: prdata_r[7:0] <= bankcfg_r;
				pdc_pkg::ADR_STATUS: begin
					prdata_r[pdc_pkg::STAT_BUSY_BIT] <= state_r != pdc_pkg::ST_IDLE;
					prdata_r[pdc_pkg::STAT_REF_BIT]  <= ref_lvl;
					prdata_r[pdc_pkg::STAT_RAS_LSB +: 4] <= ras_on_r;
				end
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// address mapping
	// ------------------------------------------------------------------
	// the 1M pair must sit first, so A23 splits pairs once it is fitted
	always_comb begin
		map = '0;
		if (!memcfg_r[pdc_pkg::MEMCFG_ILV_BIT]) begin
			if (bankcfg_r[pdc_pkg::BANK_P0_1M_BIT]) begin
				map.row = I_ADDR[21:12];
				map.col = I_ADDR[11:2];
			end else begin
				map.row = {1'b0, I_ADDR[19:11]};
				map.col = {1'b0, I_ADDR[10:2]};
			end
		end else begin
			map.bank[0] = I_ADDR[11];
			if (bankcfg_r[pdc_pkg::BANK_FOUR_BIT])
				map.bank[1] = bankcfg_r[pdc_pkg::BANK_P0_1M_BIT]
					? I_ADDR[23] : I_ADDR[21];
			if (map.bank[1] ? bankcfg_r[pdc_pkg::BANK_P1_1M_BIT]
					: bankcfg_r[pdc_pkg::BANK_P0_1M_BIT]) begin
				map.row = I_ADDR[21:12];
				map.col = {I_ADDR[22], I_ADDR[10:2]};
			end else begin
				map.row = {1'b0, I_ADDR[20:12]};
				map.col = {1'b0, I_ADDR[10:2]};
			end
		end
	end

	// a bank that has timed out is not offered as a hit
	assign hit = ras_on_r[map.bank] & ~bank_tmo[map.bank]
		& (page_row_r[map.bank] == map.row);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	assign cas_last = cnt_r == (timing_r[pdc_pkg::TIM_WAIT_BIT]
		? pdc_pkg::CAS_BASE_CYC : pdc_pkg::CAS_BASE_CYC - 3'h1);

	// arbitration happens only in idle, so nothing is cut short
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pdc_pkg::ST_IDLE: begin
				if (ref_lvl)
					state_nxt = pdc_pkg::ST_REF_OFF;
				else if (dma_go)
					state_nxt = pdc_pkg::ST_PRE;
				else if (I_CPU_REQ && !hold_lvl)
					state_nxt = hit ? pdc_pkg::ST_CAS : pdc_pkg::ST_PRE;
			end
			pdc_pkg::ST_PRE:
				if (cnt_r == pdc_pkg::PRECH_CYC - 3'h1)
					state_nxt = pdc_pkg::ST_ROW;
			pdc_pkg::ST_ROW:
				state_nxt = pdc_pkg::ST_CAS;
			pdc_pkg::ST_CAS:
				if (cas_last)
					state_nxt = is_dma_r ? pdc_pkg::ST_DMA_END : pdc_pkg::ST_DONE;
			pdc_pkg::ST_DONE:
				state_nxt = pdc_pkg::ST_IDLE;
			pdc_pkg::ST_DMA_END:
				if (!(rd_lvl || wr_lvl))
					state_nxt = pdc_pkg::ST_IDLE;
			pdc_pkg::ST_REF_OFF:
				if (cnt_r == pdc_pkg::PRECH_CYC - 3'h1)
					state_nxt = pdc_pkg::ST_REF_ON;
			pdc_pkg::ST_REF_ON:
				if (cnt_r == pdc_pkg::REF_STEPS - 3'h1)
					state_nxt = pdc_pkg::ST_REF_HOLD;
			pdc_pkg::ST_REF_HOLD:
				if (cnt_r == pdc_pkg::REF_HOLD_CYC - 3'h1)
					state_nxt = pdc_pkg::ST_IDLE;
			default:
				state_nxt = pdc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_r <= pdc_pkg::ST_IDLE;
			cnt_r   <= 3'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (state_nxt == state_r) ? cnt_r + 3'h1 : 3'h0;
		end
	end

	// request latched as the sequence leaves idle
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cur_bank_r <= 2'h0;
			cur_row_r  <= 10'h000;
			cur_col_r  <= 10'h000;
			is_dma_r   <= 1'b0;
			wr_r       <= 1'b0;
			be_r       <= 4'hF;
		end else if (state_r == pdc_pkg::ST_IDLE) begin
			cur_bank_r <= map.bank;
			cur_row_r  <= map.row;
			cur_col_r  <= map.col;
			is_dma_r   <= ~ref_lvl & dma_go;
			wr_r       <= dma_go ? wr_lvl : I_CPU_WRITE;
			be_r       <= I_BYTE_ENABLE_N;
		end
	end

	assign O_CPU_READY = state_r == pdc_pkg::ST_DONE;

	// ------------------------------------------------------------------
	// ras strobes and page registers
	// ------------------------------------------------------------------
	assign ras_set = (state_r == pdc_pkg::ST_PRE
		&& state_nxt == pdc_pkg::ST_ROW) ? 4'h1 << cur_bank_r : 4'h0;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ras_on_r <= 4'h0;
		end else begin
			case (state_r)
				pdc_pkg::ST_IDLE: begin
					ras_on_r <= ras_on_r & ~bank_tmo;
					if (state_nxt == pdc_pkg::ST_PRE)
						ras_on_r[map.bank] <= 1'b0;
					if (state_nxt == pdc_pkg::ST_REF_OFF)
						ras_on_r <= 4'h0;
				end
				pdc_pkg::ST_PRE:
					ras_on_r <= ras_on_r | ras_set;
				pdc_pkg::ST_DMA_END:
					if (state_nxt == pdc_pkg::ST_IDLE)
						ras_on_r[cur_bank_r] <= 1'b0;
				pdc_pkg::ST_REF_ON:
					ras_on_r[cnt_r[1:0]] <= 1'b1;
				pdc_pkg::ST_REF_HOLD:
					if (state_nxt == pdc_pkg::ST_IDLE)
						ras_on_r <= 4'h0;
				default:
					ras_on_r <= ras_on_r;
			endcase
		end
	end

	// one open row per bank; valid while its ras is on, except during refresh
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (int i = 0; i < 4; i++)
				page_row_r[i] <= 10'h000;
		end else if (ras_set != 4'h0) begin
			page_row_r[cur_bank_r] <= cur_row_r;
		end
	end

	// ------------------------------------------------------------------
	// ras timers
	// ------------------------------------------------------------------
	assign tmo_lim = timing_r[pdc_pkg::TIM_LONG_BIT]
		? pdc_pkg::RAS_LONG_TCK : pdc_pkg::RAS_SHORT_TCK;

	// timeout only closes a bank in idle; long dma cycles can overrun it
	for (genvar gb = 0; gb < 4; gb++) begin : g_tmr
		logic [5:0] tmr_r;

		always_ff @(posedge I_CLK or negedge I_ARST_N) begin
			if (!I_ARST_N)
				tmr_r <= 6'h00;
			else if (!ras_on_r[gb] || ras_set[gb])
				tmr_r <= 6'h00;
			else if (osc_tick && tmr_r < tmo_lim)
				tmr_r <= tmr_r + 6'h01;
		end

		assign bank_tmo[gb] = ras_on_r[gb] & (tmr_r >= tmo_lim);

		AST_TMO_CLOSE: assert property (
			(bank_tmo[gb] && state_r == pdc_pkg::ST_IDLE) |=> !ras_on_r[gb])
			else $error("ras stayed on after timeout");
		AST_TMR_RESTART: assert property (
			$rose(ras_on_r[gb]) |-> tmr_r == 6'h00)
			else $error("ras timer not restarted");
	end

	// ------------------------------------------------------------------
	// dram outputs
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ref_row_r <= 10'h000;
		end else if (state_r == pdc_pkg::ST_REF_HOLD
				&& state_nxt == pdc_pkg::ST_IDLE) begin
			ref_row_r <= ref_row_r + 10'h001;
		end
	end

	// all four lanes carry 8 data bits plus their parity bit
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cas_n_r <= 4'hF;
			we_n_r  <= 1'b1;
			addr_r  <= 10'h000;
		end else begin
			cas_n_r <= 4'hF;
			we_n_r  <= 1'b1;
			case (state_nxt)
				pdc_pkg::ST_PRE, pdc_pkg::ST_ROW:
					addr_r <= cur_row_r;
				pdc_pkg::ST_CAS, pdc_pkg::ST_DMA_END: begin
					addr_r  <= (state_r == pdc_pkg::ST_IDLE) ? map.col : cur_col_r;
					cas_n_r <= (state_r == pdc_pkg::ST_IDLE)
						? I_BYTE_ENABLE_N : be_r;
					we_n_r  <= (state_r == pdc_pkg::ST_IDLE)
						? ~I_CPU_WRITE : ~wr_r;
				end
				pdc_pkg::ST_REF_OFF, pdc_pkg::ST_REF_ON, pdc_pkg::ST_REF_HOLD:
					addr_r <= ref_row_r;
				default:
					addr_r <= addr_r;
			endcase
		end
	end

	assign O_DRAM = {~ras_on_r, cas_n_r, we_n_r, addr_r};

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_stagger;
		ras_on_r == 4'h0 ##1 ras_on_r == 4'h1 ##1 ras_on_r == 4'h3
			##1 ras_on_r == 4'h7 ##1 ras_on_r == 4'hF;
	endsequence

	sequence s_row_open;
		state_r == pdc_pkg::ST_ROW && ras_on_r[cur_bank_r]
			&& page_row_r[cur_bank_r] == cur_row_r;
	endsequence

	AST_REF_PRIO: assert property (
		(state_r == pdc_pkg::ST_IDLE && ref_lvl) |=>
			state_r == pdc_pkg::ST_REF_OFF)
		else $error("refresh not granted first");
	AST_DMA_GRANT: assert property (
		(state_r == pdc_pkg::ST_IDLE && !ref_lvl && dma_go) |=>
			(state_r == pdc_pkg::ST_PRE && is_dma_r))
		else $error("dma not started on hold ack");
	AST_NONPREEMPT: assert property (
		(state_r == pdc_pkg::ST_DMA_END && ref_lvl && (rd_lvl || wr_lvl))
			|=> state_r == pdc_pkg::ST_DMA_END)
		else $error("refresh preempted an access");
	AST_DMA_NOHIT: assert property (
		$rose(state_r == pdc_pkg::ST_CAS) && is_dma_r |->
			$past(state_r) == pdc_pkg::ST_ROW)
		else $error("dma took the open page path");
	AST_HIT_CAS: assert property (
		(state_r == pdc_pkg::ST_IDLE && !ref_lvl && !hold_lvl && I_CPU_REQ
			&& hit) |=> (state_r == pdc_pkg::ST_CAS && ras_on_r[cur_bank_r]))
		else $error("page hit did not go straight to cas");
	AST_MISS_SEQ: assert property (
		$rose(state_r == pdc_pkg::ST_PRE) |->
			!ras_on_r[cur_bank_r] ##[1:3] s_row_open)
		else $error("miss sequence out of order");
	AST_WAIT_ON: assert property (
		($rose(state_r == pdc_pkg::ST_CAS) && timing_r[pdc_pkg::TIM_WAIT_BIT])
			|=> state_r == pdc_pkg::ST_CAS)
		else $error("wait state missing");
	AST_WAIT_OFF: assert property (
		($rose(state_r == pdc_pkg::ST_CAS) && !timing_r[pdc_pkg::TIM_WAIT_BIT])
			|=> state_r != pdc_pkg::ST_CAS)
		else $error("unexpected wait state");
	AST_REF_STAGGER: assert property (
		$rose(state_r == pdc_pkg::ST_REF_ON) |-> s_stagger)
		else $error("refresh ras not staggered");
	AST_DMA_ONE: assert property (
		(state_r == pdc_pkg::ST_DMA_END && !rd_lvl && !wr_lvl) |=>
			(state_r == pdc_pkg::ST_IDLE && !ras_on_r[cur_bank_r]))
		else $error("dma cycle not closed");
	AST_DMA_LANES: assert property (
		(state_r == pdc_pkg::ST_CAS && is_dma_r) |-> O_DRAM.cas_n == be_r)
		else $error("dma cas lanes differ from enables");

endmodule

// ---- sim/pdc_dram_model.sv ----
/*
 * dram bank model: records the row strobed into each bank and counts
 * column strobes; assumes it samples on the controller clock
 */
module pdc_dram_model (
	// clock
	input  wire logic               i_clk,
	// dram pins
	input  wire pdc_pkg::pdc_dram_s i_dram,
	// observation
	output logic [3:0][9:0]         o_row,
	output int                      o_cas_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ras_q = 4'hF;
	logic       cas_q = 1'h0;
	int         cnt_q = 0;
	// ------------------------------------------------------------------
	// row capture and column count
	// ------------------------------------------------------------------
	// one 36 bit word per bank, so only the strobes matter here
	always @(posedge i_clk) begin
		for (int b = 0; b < 4; b++) begin
			if (ras_q[b] && !i_dram.ras_n[b])
				o_row[b] <= i_dram.addr;
		end
		ras_q <= i_dram.ras_n;
	end
	// lanes merged: a strobe on any lane is one access
	always @(posedge i_clk) begin
		if (!cas_q && i_dram.cas_n != 4'hF)
			cnt_q <= cnt_q + 1;
		cas_q <= (i_dram.cas_n != 4'hF);
	end
	assign o_cas_cnt = cnt_q;
endmodule

// ---- sim/testbench.sv ----
/*
 * testbench of the dram controller: apb and cpu tasks, dma, refresh
 * and ras timeout runs; assumes a 20 MHz clock and one bank model
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int TICK = 16; // osc period in clocks, near 840 ns
	logic I_CLK = 1'h0, I_ARST_N = 1'h0, I_PSEL = 1'h0;
	logic I_PENABLE = 1'h0, I_PWRITE = 1'h0, I_CPU_REQ = 1'h0;
	logic I_CPU_WRITE = 1'h0, I_DMA_HOLD_ACK = 1'h0;
	logic I_XBUS_MEM_READ_CMD = 1'h0, I_XBUS_MEM_WRITE_CMD = 1'h0;
	logic I_REFRESH_REQUEST = 1'h0, I_OSC_DIV_TWELVE_CLOCK = 1'h0;
	logic [11:0] I_PADDR = 12'h0;
	logic [31:0] I_PWDATA = 32'h0;
	logic [23:2] I_ADDR = 22'h0;
	logic [3:0]  I_BYTE_ENABLE_N = 4'h0;
	logic [31:0] O_PRDATA, rd;
	logic        O_PREADY, O_PSLVERR, O_CPU_READY, er, rose;
	pdc_pkg::pdc_dram_s O_DRAM;
	logic [3:0][9:0] row;
	logic [3:0]  cs;
	logic [3:0]  rs [5] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
	logic [11:0] ra [3] = '{12'h20, 12'h4C, 12'h54};
	logic [31:0] rv [3] = '{32'h0, 32'h40, 32'h0};
	int cas_cnt, c0, idx, oc = 0, err_total = 0, n_compared = 0;

	pdc_ctrl pdc_ctrl_inst (.I_CLK, .I_ARST_N, .I_PSEL, .I_PENABLE,
		.I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR,
		.I_CPU_REQ, .I_CPU_WRITE, .I_ADDR, .I_BYTE_ENABLE_N, .O_CPU_READY,
		.I_DMA_HOLD_ACK, .I_XBUS_MEM_READ_CMD, .I_XBUS_MEM_WRITE_CMD,
		.I_REFRESH_REQUEST, .I_OSC_DIV_TWELVE_CLOCK, .O_DRAM);
	pdc_dram_model pdc_dram_model_inst (.i_clk(I_CLK), .i_dram(O_DRAM),
		.o_row(row), .o_cas_cnt(cas_cnt));

	initial forever #25 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		oc <= (oc + 1) % (TICK / 2);
		if (oc == TICK / 2 - 1)
			I_OSC_DIV_TWELVE_CLOCK <= ~I_OSC_DIV_TWELVE_CLOCK;
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge I_CLK);
		I_PSEL <= 1'h1;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_CLK);
		I_PENABLE <= 1'h1;
		do begin
			@(posedge I_CLK);
			k++;
		end while (O_PREADY !== 1'h1 && k < 20);
		if (O_PREADY !== 1'h1) begin
			err_total++;
			$display("Error %0t: apb transfer not answered", $time);
		end
		rd = O_PRDATA;
		er = O_PSLVERR;
		I_PSEL <= 1'h0;
		I_PENABLE <= 1'h0;
	endtask
	// cycles counted from the raised request to the ready pulse
	task automatic cpu(input logic [23:0] a, input int exp_n);
		int k;
		logic wn;
		k = 0;
		wn = 1'hx;
		@(posedge I_CLK);
		I_ADDR <= a[23:2];
		I_BYTE_ENABLE_N <= 4'h0;
		I_CPU_WRITE <= ~I_CPU_WRITE;
		I_CPU_REQ <= 1'h1;
		do begin
			@(negedge I_CLK);
			k++;
			if (O_DRAM.cas_n !== 4'hF)
				wn = O_DRAM.we_n;
		end while (O_CPU_READY !== 1'h1 && k < 60);
		@(posedge I_CLK);
		I_CPU_REQ <= 1'h0;
		chk(32'(k), 32'(exp_n));
		chk({31'h0, wn}, {31'h0, ~I_CPU_WRITE});
	endtask
	task automatic complete_run;
		$display("mismatches %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		#(50 * 6000);
		err_total++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge I_CLK);
		I_ARST_N <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			apb(1'h0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'h0, 12'h7C, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'h1, 12'h4C, 32'hFF);
		apb(1'h0, 12'h4C, 32'h0);
		chk(rd, 32'hC0);
		apb(1'h1, 12'h4C, 32'h40);
		cpu(24'h052800, 7);
		chk(32'(row[0]), 32'h0A5);
		cpu(24'h052804, 4);
		apb(1'h1, 12'h4C, 32'h00);
		cpu(24'h052808, 3);
		apb(1'h1, 12'h20, 32'h01);
		cpu(24'h052800, 6);
		chk(32'(row[1]), 32'h052);
		apb(1'h1, 12'h54, 32'h01);
		cpu(24'h252800, 6);
		chk(32'(row[3]), 32'h052);
		apb(1'h1, 12'h20, 32'h00);
		apb(1'h1, 12'h54, 32'h00);
		idx = 0;
		for (int i = 0; i < 30; i++) begin
			@(posedge I_CLK);
			I_REFRESH_REQUEST <= (i < 6);
			@(negedge I_CLK);
			if (idx < 5 && O_DRAM.ras_n === rs[idx])
				idx++;
		end
		chk(32'(idx), 32'h5);
		cpu(24'h052800, 6);
		c0 = cas_cnt;
		cs = 4'hF;
		rose = 1'h0;
		idx = 0;
		@(posedge I_CLK);
		I_BYTE_ENABLE_N <= 4'hA;
		I_DMA_HOLD_ACK <= 1'h1;
		I_XBUS_MEM_READ_CMD <= 1'h1;
		// refresh raised mid dma must wait for the commands to drop
		for (int i = 0; i < 32; i++) begin
			@(posedge I_CLK);
			I_DMA_HOLD_ACK <= (i < 14);
			I_XBUS_MEM_READ_CMD <= (i < 14);
			I_REFRESH_REQUEST <= (i >= 8 && i < 19);
			@(negedge I_CLK);
			cs = cs & O_DRAM.cas_n;
			rose = rose | O_DRAM.ras_n[0];
			if (O_DRAM.ras_n === 4'h0)
				idx++;
		end
		chk({28'h0, cs}, 32'hA);
		chk(32'(rose), 32'h1);
		chk(32'(cas_cnt - c0), 32'h1);
		chk(32'(idx), 32'h2);
		cpu(24'h052800, 6);
		repeat (8 * TICK) @(negedge I_CLK);
		chk(32'(O_DRAM.ras_n[0]), 32'h0);
		repeat (6 * TICK) @(negedge I_CLK);
		chk(32'(O_DRAM.ras_n[0]), 32'h1);
		apb(1'h1, 12'h4C, 32'h80);
		cpu(24'h052800, 6);
		repeat (20 * TICK) @(negedge I_CLK);
		chk(32'(O_DRAM.ras_n[0]), 32'h0);
		complete_run;
	end
endmodule
